// ===== dma_xfer_chk.sv
`timescale 1ns/100ps
`default_nettype none
module dma_xfer_chk
  import dma_xfer_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic arst_n, // Reset, active low
  input wire logic [31:0] addr, // Port address
  input wire logic [15:0] wdata, // Port write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic [15:0] rdata // Port read data
);
  logic rc_q; // Control read answered now
  logic dir_q; // Last written direction
  logic ok_q; // Count read allowed
  logic cw; // Control write
  assign cw = wr && addr == CTRL_ADDR;
  // Port history
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rc_q <= 1'b0;
      dir_q <= 1'b0;
      ok_q <= 1'b0;
    end else begin
      rc_q <= rd && addr == CTRL_ADDR;
      dir_q <= cw ? wdata[B_DIR] : dir_q;
      ok_q <= cw ? 1'b0 : ok_q | (rc_q && (rdata[B_VALID] || rdata[B_READY]));
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  property p_rdy_vld;
    rc_q && rdata[B_READY] |-> rdata[B_VALID];
  endproperty
  a_rdy_vld: assert property (p_rdy_vld) else $error("ready without valid");
  property p_err_clr;
    cw && wdata[B_EN] ##1 rd && addr == CTRL_ADDR |=> !rdata[B_ERR];
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("error kept on start");
  property p_rdy_busy;
    rc_q && rdata[B_READY] |-> rdata[B_BUSY];
  endproperty
  a_rdy_busy: assert property (p_rdy_busy) else $error("ready while idle");
  property p_poll;
    rd && addr == SIZE_ADDR |-> ok_q;
  endproperty
  a_poll: assert property (p_poll) else $error("count read too early");
  property p_short;
    rc_q && !rdata[B_BUSY] && !rdata[B_LONG] && !rdata[B_ERR] |-> !rdata[B_EN];
  endproperty
  a_short: assert property (p_short) else $error("enable kept in short mode");
  property p_long;
    rc_q && !rdata[B_BUSY] && rdata[B_LONG] && rdata[B_EN]
      |-> ##[0:8] (cw && !wdata[B_EN]);
  endproperty
  a_long: assert property (p_long) else $error("long mode not closed");
  property p_dir;
    rc_q |-> rdata[B_DIR] == dir_q;
  endproperty
  a_dir: assert property (p_dir) else $error("direction lost");
  property p_idle;
    !$past(rd) |-> rdata == 16'h0000;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside slot");
endmodule : dma_xfer_chk
`default_nettype wire

// ===== dma_xfer_dev.sv
`timescale 1ns/100ps
`default_nettype none
module dma_xfer_dev
  import dma_xfer_pkg::*;
#(
  parameter logic [3:0] SETTLE = SETTLE_CYCLES
) (
  input wire logic mclk, // 40 MHz clock
  input wire logic arst_n, // Async reset, active low
  dma_xfer_if.dev pp, // Processor port
  input wire logic [LEN_W-1:0] buf_avail, // Bytes held in socket buffer
  input wire logic [LEN_W-1:0] buf_size, // Size of socket buffer
  input wire logic sock_ready, // Socket can move data now
  input wire logic beat, // One byte moved while xfer_go
  input wire logic dma_fault, // Transfer error pulse
  output logic [SOCK_W-1:0] sock_sel, // Selected socket
  output logic xfer_dir, // 1 ingress, 0 egress
  output logic xfer_busy, // Transfer in progress
  output logic xfer_go // Bytes may move this cycle
);

  typedef struct packed {
    logic [SOCK_W-1:0] sock;
    logic en;
    logic dir;
    logic lng;
    logic busy;
    logic err;
    logic valid;
    logic ready;
    logic [LEN_W-1:0] size;
    logic [3:0] settle;
    logic [15:0] rdata;
  } dev_s;

  dev_s q;
  dev_s d;

  // Pack control fields into the register view
  function automatic logic [15:0] ctrl_word(input dev_s s);
    logic [15:0] w;
    w = CTRL_RST;
    w[B_READY] = s.ready;
    w[B_ERR] = s.err;
    w[B_BUSY] = s.busy;
    w[B_VALID] = s.valid;
    w[B_LONG] = s.lng;
    w[B_DIR] = s.dir;
    w[B_EN] = s.en;
    w[SOCK_LSB +: SOCK_W] = s.sock;
    return w;
  endfunction : ctrl_word

  // Count to load for the chosen direction
  function automatic logic [LEN_W-1:0] init_len(input logic dir,
      input logic [LEN_W-1:0] avail, input logic [LEN_W-1:0] size);
    return dir ? size : avail;
  endfunction : init_len

  logic ctrl_wr;
  logic size_wr;
  logic last_beat;

  // Access decode
  assign ctrl_wr = pp.wr && (pp.addr == CTRL_ADDR);
  assign size_wr = pp.wr && (pp.addr == SIZE_ADDR);
  assign last_beat = q.ready && beat && (q.size == {{(LEN_W-1){1'b0}}, 1'b1});

  // Next-state logic
  always_comb begin
    d = q;
    d.rdata = 16'h0000;

    // Read data one cycle after the strobe, zero if unmapped
    if (pp.rd) begin
      case (pp.addr)
        CTRL_ADDR: d.rdata = ctrl_word(q);
        SIZE_ADDR: d.rdata = q.size;
        default: d.rdata = 16'h0000;
      endcase
    end

    // Settle window, then count matches the socket
    if (q.settle != 4'h0) begin
      d.settle = q.settle - 4'h1;
      if (q.settle == 4'h1) begin
        d.valid = 1'b1;
        d.size = init_len(q.dir, buf_avail, buf_size);
      end
    end

    // Bytes moved count down the remaining size
    if (q.ready && beat) begin
      d.size = q.size - {{(LEN_W-1){1'b0}}, 1'b1};
    end

    // Buffer end: stop; short mode drops enable too
    if (last_beat) begin
      d.busy = 1'b0;
      if (!q.lng) begin
        d.en = 1'b0;
      end
    end

    // Written count becomes the amount to move
    if (size_wr) begin
      d.size = pp.wdata[LEN_W-1:0];
    end

    // Control write: fields, start or abort
    if (ctrl_wr) begin
      d.sock = pp.wdata[SOCK_LSB +: SOCK_W];
      d.dir = pp.wdata[B_DIR];
      d.lng = pp.wdata[B_LONG];
      d.valid = 1'b0;
      d.settle = SETTLE;
      if (pp.wdata[B_EN]) begin
        d.en = 1'b1;
        d.busy = 1'b1;
        d.err = 1'b0;
      end else if (q.en) begin
        d.en = 1'b0;
        d.busy = 1'b0;
      end
    end

    // Fault ends a transfer already busy; set wins over the start clear
    if (dma_fault) begin
      d.err = 1'b1;
      if (q.busy) begin
        d.busy = 1'b0;
      end
    end

    // Ready only with a valid nonzero count on a ready socket
    d.ready = d.busy && d.valid && sock_ready && (d.size != '0);
  end

  // State register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state
  assign pp.rdata = q.rdata;
  assign sock_sel = q.sock;
  assign xfer_dir = q.dir;
  assign xfer_busy = q.busy;
  assign xfer_go = q.ready;

endmodule : dma_xfer_dev
`default_nettype wire

// ===== dma_xfer_host.sv
// Local design decision: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module dma_xfer_host
  import dma_xfer_pkg::*;
(
  input wire logic mclk, // 40 MHz clock
  input wire logic arst_n, // Async reset, active low
  input wire logic [2:0] sw_addr, // Software register offset
  input wire logic [15:0] sw_wdata, // Software write data
  input wire logic sw_wr, // Software write strobe
  input wire logic sw_rd, // Software read strobe
  output logic [15:0] sw_rdata, // Read data, cycle after strobe
  output logic irq, // Unmasked event pending
  dma_xfer_if.host pp // Processor port to device
);

  typedef struct packed {
    host_st_e st;
    logic [SOCK_W-1:0] sock;
    logic dir;
    logic lng;
    logic [LEN_W-1:0] trim;
    logic [LEN_W-1:0] count;
    logic [15:0] ctrl;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] mask;
    logic rd_d1;
    logic [31:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] sw_rdata;
    logic irq;
  } host_s;

  host_s q;
  host_s d;

  // Control word with chosen fields and enable
  function automatic logic [15:0] ctrl_cmd(input host_s s, input logic en);
    logic [15:0] w;
    w = CTRL_RST;
    w[SOCK_LSB +: SOCK_W] = s.sock;
    w[B_DIR] = s.dir;
    w[B_LONG] = s.lng;
    w[B_EN] = en;
    return w;
  endfunction : ctrl_cmd

  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;

  // Next-state logic
  always_comb begin
    d = q;
    d.wr = 1'b0;
    d.rd = 1'b0;
    d.rd_d1 = q.rd;
    d.sw_rdata = 16'h0000;
    ev_set = '0;
    ev_clr = '0;

    // Software reads
    if (sw_rd) begin
      case (sw_addr)
        SW_CMD: d.sw_rdata = ctrl_cmd(q, 1'b0);
        SW_TRIM: d.sw_rdata = q.trim;
        SW_STAT: d.sw_rdata = {q.ctrl[15:12], 11'h000, q.st != ST_IDLE};
        SW_COUNT: d.sw_rdata = q.count;
        SW_EVENT: d.sw_rdata = {13'h0000, q.ev};
        SW_MASK: d.sw_rdata = {13'h0000, q.mask};
        default: d.sw_rdata = 16'h0000;
      endcase
    end

    // Transfer sequencer
    case (q.st)
      ST_IDLE: d.st = d.st;
      ST_START: begin
        d.addr = CTRL_ADDR;
        d.wdata = ctrl_cmd(q, 1'b1);
        d.wr = 1'b1;
        d.st = ST_POLL_RD;
      end
      ST_POLL_RD: begin
        d.addr = CTRL_ADDR;
        d.rd = 1'b1;
        d.st = ST_POLL_WT;
      end
      ST_POLL_WT: begin
        if (q.rd_d1) begin
          d.ctrl = pp.rdata;
          if (pp.rdata[B_ERR]) begin
            ev_set[EV_ERR] = 1'b1;
            d.st = ST_IDLE;
          end else if (pp.rdata[B_VALID] || pp.rdata[B_READY]) begin
            d.st = ST_SIZE_RD;
          end else begin
            d.st = ST_POLL_RD;
          end
        end
      end
      ST_SIZE_RD: begin
        d.addr = SIZE_ADDR;
        d.rd = 1'b1;
        d.st = ST_SIZE_WT;
      end
      ST_SIZE_WT: begin
        if (q.rd_d1) begin
          d.count = pp.rdata[LEN_W-1:0];
          if (q.dir && q.trim != '0 && q.trim < pp.rdata[LEN_W-1:0]) begin
            d.st = ST_TRIM;
          end else begin
            d.st = ST_BUSY_RD;
          end
        end
      end
      ST_TRIM: begin
        d.addr = SIZE_ADDR;
        d.wdata = q.trim;
        d.wr = 1'b1;
        d.count = q.trim;
        d.st = ST_BUSY_RD;
      end
      ST_BUSY_RD: begin
        d.addr = CTRL_ADDR;
        d.rd = 1'b1;
        d.st = ST_BUSY_WT;
      end
      ST_BUSY_WT: begin
        if (q.rd_d1) begin
          d.ctrl = pp.rdata;
          ev_set[EV_READY] = pp.rdata[B_READY];
          if (pp.rdata[B_BUSY]) begin
            d.st = ST_BUSY_RD;
          end else if (pp.rdata[B_ERR]) begin
            ev_set[EV_ERR] = 1'b1;
            d.st = pp.rdata[B_EN] ? ST_STOP : ST_IDLE;
          end else if (pp.rdata[B_EN]) begin
            d.st = ST_STOP;
          end else begin
            ev_set[EV_DONE] = 1'b1;
            d.st = ST_IDLE;
          end
        end
      end
      ST_STOP: begin
        d.addr = CTRL_ADDR;
        d.wdata = ctrl_cmd(q, 1'b0);
        d.wr = 1'b1;
        ev_set[EV_DONE] = 1'b1;
        d.st = ST_IDLE;
      end
      default: d.st = ST_IDLE;
    endcase

    // Software writes, after the sequencer so an abort is never lost
    if (sw_wr) begin
      case (sw_addr)
        SW_CMD: begin
          if (q.st == ST_IDLE && sw_wdata[C_GO]) begin
            d.sock = sw_wdata[SOCK_LSB +: SOCK_W];
            d.dir = sw_wdata[B_DIR];
            d.lng = sw_wdata[B_LONG];
            d.st = ST_START;
          end else if (q.st != ST_IDLE && sw_wdata[C_ABORT]) begin
            d.st = ST_STOP;
          end
        end
        SW_TRIM: d.trim = sw_wdata[LEN_W-1:0];
        SW_EVENT: ev_clr = sw_wdata[EV_W-1:0];
        SW_MASK: d.mask = sw_wdata[EV_W-1:0];
        default: d.mask = q.mask;
      endcase
    end

    // Sticky events, set wins over write-one clear
    d.ev = (q.ev & ~ev_clr) | ev_set;
    d.irq = |(d.ev & d.mask);
  end

  // State register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state
  assign sw_rdata = q.sw_rdata;
  assign irq = q.irq;
  assign pp.addr = q.addr;
  assign pp.wdata = q.wdata;
  assign pp.wr = q.wr;
  assign pp.rd = q.rd;

endmodule : dma_xfer_host
`default_nettype wire

// ===== dma_xfer_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dma_xfer_if;
  logic [31:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  // Processor side issues accesses
  modport host (output addr, output wdata, output wr, output rd, input rdata);
  // Device side answers them
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
endinterface : dma_xfer_if
`default_nettype wire

// ===== dma_xfer_pkg.sv
`default_nettype none
package dma_xfer_pkg;
  // Byte count width
  localparam int LEN_W = 16;
  // Device register byte addresses
  localparam logic [31:0] CTRL_ADDR = 32'hE0017E2C;
  localparam logic [31:0] SIZE_ADDR = 32'hE0017E30;
  // Transfer control field positions
  localparam int B_READY = 15;
  localparam int B_ERR = 14;
  localparam int B_BUSY = 13;
  localparam int B_VALID = 12;
  localparam int B_LONG = 10;
  localparam int B_DIR = 9;
  localparam int B_EN = 8;
  localparam int SOCK_LSB = 0;
  localparam int SOCK_W = 8;
  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] SIZE_RST = 16'h0000;
  // Cycles the length valid flag stays low after a control write
  localparam logic [3:0] SETTLE_CYCLES = 4'h4;
  // Controller software register offsets
  localparam logic [2:0] SW_CMD = 3'h0;
  localparam logic [2:0] SW_TRIM = 3'h1;
  localparam logic [2:0] SW_STAT = 3'h2;
  localparam logic [2:0] SW_COUNT = 3'h3;
  localparam logic [2:0] SW_EVENT = 3'h4;
  localparam logic [2:0] SW_MASK = 3'h5;
  // Command bits besides the control layout
  localparam int C_GO = 8;
  localparam int C_ABORT = 11;
  // Event bits
  localparam int EV_DONE = 0;
  localparam int EV_ERR = 1;
  localparam int EV_READY = 2;
  localparam int EV_W = 3;
  // Controller sequencer states, Gray from each state to the next in the listed order
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_START = 4'h1,
    ST_POLL_RD = 4'h3,
    ST_POLL_WT = 4'h2,
    ST_SIZE_RD = 4'h6,
    ST_SIZE_WT = 4'h7,
    ST_TRIM = 4'h5,
    ST_BUSY_RD = 4'h4,
    ST_BUSY_WT = 4'hC,
    ST_STOP = 4'hD
  } host_st_e;
endpackage : dma_xfer_pkg
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import dma_xfer_pkg::*;
;
  typedef struct {logic [15:0] cmd, av, sz, trim, cnt, mv;} row_s;
  logic mclk = 1'b0, arst_n = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0, irq;
  logic [2:0] sw_addr = 3'h0;
  logic [15:0] sw_wdata = 16'h0000, sw_rdata, buf_avail = 16'h0000, buf_size = 16'h0000, v;
  logic sock_ready = 1'b1, beat = 1'b0, dma_fault = 1'b0, xfer_dir, xfer_busy, xfer_go, dir_c;
  logic [7:0] sock_sel, sock_c;
  int miscompares = 0, num_checks = 0, n_beats = 0, n_go = 0, b0;
  row_s rows [4] = '{
    '{16'h0103, 16'h0005, 16'h0009, 16'h0000, 16'h0005, 16'h0005},
    '{16'h0344, 16'h0002, 16'h0006, 16'h0003, 16'h0003, 16'h0003},
    '{16'h0781, 16'h0001, 16'h0004, 16'h0000, 16'h0004, 16'h0004},
    '{16'h05FF, 16'h0002, 16'h0007, 16'h0001, 16'h0002, 16'h0002}};
  dma_xfer_if bus();
  dma_xfer_dev u_dma_xfer_dev (.mclk(mclk), .arst_n(arst_n), .pp(bus), .buf_avail(buf_avail),
    .buf_size(buf_size), .sock_ready(sock_ready), .beat(beat), .dma_fault(dma_fault),
    .sock_sel(sock_sel), .xfer_dir(xfer_dir), .xfer_busy(xfer_busy), .xfer_go(xfer_go));
  dma_xfer_host u_dma_xfer_host (.mclk(mclk), .arst_n(arst_n), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq), .pp(bus));
  dma_xfer_chk u_dma_xfer_chk (.mclk(mclk), .arst_n(arst_n), .addr(bus.addr),
    .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata));
  // Clock
  always #12.5 mclk = ~mclk;
  // Socket side: a byte in each cycle that follows a cycle of go
  always @(posedge mclk) begin
    beat <= xfer_go;
    if (beat && xfer_go) n_beats++;
    if (xfer_go) begin
      n_go++;
      sock_c <= sock_sel;
      dir_c <= xfer_dir;
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic sw_write(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge mclk);
    sw_wr <= 1'b0;
  endtask : sw_write
  task automatic sw_read(input logic [2:0] a, output logic [15:0] d);
    @(posedge mclk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge mclk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask : sw_read
  task automatic wait_ev(input logic [15:0] m);
    v = 16'h0000;
    for (int i = 0; i < 300 && (v & m) == 16'h0000; i++) sw_read(SW_EVENT, v);
    if ((v & m) == 16'h0000) begin
      miscompares++;
      $display("BAD %0t wait ran out", $time);
      print_verdict();
    end
  endtask : wait_ev
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask : settle
  initial begin
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    // Reset state
    settle();
    check({15'h0000, xfer_busy}, 16'h0000);
    sw_read(SW_STAT, v);
    check(v, 16'h0000);
    $display("reset test done");
    // Fault with no ready socket, then interrupt mask and clear
    sock_ready <= 1'b0;
    buf_avail <= 16'h0004;
    sw_write(SW_CMD, 16'h0101);
    repeat (20) @(posedge mclk);
    dma_fault <= 1'b1;
    @(posedge mclk);
    dma_fault <= 1'b0;
    wait_ev(16'h0002);
    check({15'h0000, xfer_busy}, 16'h0000);
    check({15'h0000, irq}, 16'h0000);
    sw_write(SW_MASK, 16'h0002);
    settle();
    check({15'h0000, irq}, 16'h0001);
    sw_write(SW_EVENT, 16'h0007);
    settle();
    check({15'h0000, irq}, 16'h0000);
    sock_ready <= 1'b1;
    $display("fault test done");
    // Table of transfers
    foreach (rows[r]) begin
      buf_avail <= rows[r].av;
      buf_size <= rows[r].sz;
      sw_write(SW_TRIM, rows[r].trim);
      b0 = n_beats;
      // Socket held back until the count is read and trimmed
      sock_ready <= 1'b0;
      sw_write(SW_CMD, rows[r].cmd);
      repeat (40) @(posedge mclk);
      sock_ready <= 1'b1;
      wait_ev(16'h0001);
      sw_read(SW_COUNT, v);
      check(v, rows[r].cnt);
      check(16'(n_beats - b0), rows[r].mv);
      check({8'h00, sock_c}, {8'h00, rows[r].cmd[7:0]});
      check({15'h0000, dir_c}, {15'h0000, rows[r].cmd[9]});
      sw_read(SW_EVENT, v);
      check(v, 16'h0005);
      sw_write(SW_EVENT, 16'h0007);
      $display("transfer row %0d done", r);
    end
    // Zero length never ready, then abort
    buf_avail <= 16'h0000;
    b0 = n_go;
    sw_write(SW_CMD, 16'h0102);
    repeat (60) @(posedge mclk);
    check(16'(n_go - b0), 16'h0000);
    sw_write(SW_CMD, 16'h0800);
    for (int i = 0; i < 50 && xfer_busy !== 1'b0; i++) @(posedge mclk);
    #1 check({15'h0000, xfer_busy}, 16'h0000);
    $display("zero length test done");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
